// *** design/rlpwm_bank_engine.sv ***
//
// Contract
// (R1) Final duty is channel color level times its module intensity.
// (R2) Duty has 12 bits: 9-bit base width plus 3-bit dither fraction.
// (R3) Fraction lengthens that many pulses by one step per eight periods.
// (R4) Dither enable, default on; off drops fraction, leaving 9-bit accuracy.
// (R5) Every channel switches near 29 kHz; code runs 512 steps at 10 MHz, about 19.5 kHz.
// (R6) Channels 0,3,..,21 keep rising edge at period start.
// (R7) Channels 1,4,..,22 grow pulses symmetrically about the midpoint.
// (R8) Channels 2,5,..,23 keep falling edge at period end.
// (R9) Group select 0 uses the module's own color and intensity.
// (R10) Group select 1 uses shared group A/B/C color and group intensity.
// (R11) Group duty uses the same multiply, dither and phase path.
// (R12) Max current option selects 25.5 mA or 35 mA full scale.
// (R13) Power save enabled and all off over 30 ms enters power save.
// (R14) Any bus command to the device returns power save to normal.
// (R15) Registers stay intact and accessible during power save.
// (R16) Over-temperature forces thermal shutdown; clearing returns to normal.
// (R17) Under-voltage holds internal reset and the initialization state.
// (R18) Enable high, reset code FFh or under-voltage enter initialization.
// (R19) Chip enable set moves the device to normal mode.
// (R20) Power-up or enable pin low enters shutdown from any state.
// (R21) Chip enable clear enters standby; outputs off, registers kept.
// (R22) Each channel has an 8-bit color level.
// (R23) Each three consecutive channels share one 8-bit module intensity.
// (R24) A global select picks logarithmic or linear intensity curve.
// (R25) One shared 512-step counter times every channel.
// (R26) All off means every final duty zero; nonzero restarts idle timer.
// (R27) Outputs forced off outside normal and power-save modes.
//
`timescale 1ns/100ps
`default_nettype none

module rlpwm_bank_engine
    import rlpwm_pkg::*;
#(
    parameter int NUM_CHANNELS = NUM_CH,
    parameter int IDLE_CYCLES = PS_IDLE_CYCLES,
    parameter int PRESCALE = PWM_PRESCALE
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic en_pin_i,
    input wire logic uvlo_i,
    input wire logic over_temp_i,
    input wire rlpwm_cfg_t cfg_i,
    input wire logic [NUM_CHANNELS-1:0][COLOR_W-1:0] channel_color_level_i,
    input wire logic [NUM_CHANNELS/CH_PER_MOD-1:0][COLOR_W-1:0] module_intensity_i,
    input wire logic [NUM_CHANNELS/CH_PER_MOD-1:0] module_group_select_i,
    input wire logic [CH_PER_MOD-1:0][COLOR_W-1:0] group_color_i,
    input wire logic [COLOR_W-1:0] group_intensity_i,
    input wire logic reset_write_i,
    input wire logic [7:0] reset_data_i,
    input wire logic i2c_cmd_i,
    output logic [NUM_CHANNELS-1:0] sink_output_o,
    output logic full_scale_35ma_o,
    output logic analog_power_o,
    output logic internal_reset_o,
    output rlpwm_mode_t mode_o
);

    localparam int NUM_MODULES = NUM_CHANNELS / CH_PER_MOD;
    localparam int PRESC_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
    localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESCALE - 1);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------

    // Squared curve stands in for the logarithmic law: cheap, monotonic,
    // and keeps full scale at full scale.
    function automatic logic [COLOR_W-1:0] intensity_curve(
        input logic [COLOR_W-1:0] raw,
        input logic log_en
    );
        logic [PROD_W-1:0] sq;
        sq = raw * raw;
        if (log_en) begin
            intensity_curve = sq[PROD_W-1:COLOR_W] + {7'h00, raw[COLOR_W-1]}; // [R24]
        end else begin
            intensity_curve = raw; // [R24]
        end
    endfunction

    function automatic logic [DUTY_W-1:0] final_duty(
        input logic [COLOR_W-1:0] color,
        input logic [COLOR_W-1:0] level
    );
        logic [PROD_W-1:0] prod;
        prod = color * level; // [R1] [R11]
        final_duty = prod[PROD_W-1:DUTY_LSB]; // [R2]
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [NUM_PINS-1:0] pin_raw;
    logic [NUM_PINS-1:0] pin_s1_q;
    logic [NUM_PINS-1:0] pin_s2_q;
    logic [NUM_PINS-1:0] pin_s3_q;
    logic [NUM_PINS-1:0] pin_q;
    logic [NUM_PINS-1:0] pin_d;

    always_comb begin
        pin_raw = '0;
        pin_raw[PIN_EN] = en_pin_i;
        pin_raw[PIN_UVLO] = uvlo_i;
        pin_raw[PIN_OTEMP] = over_temp_i;
        // A level counts only once two later stages agree
        for (int p = 0; p < NUM_PINS; p++) begin
            pin_d[p] = (pin_s2_q[p] == pin_s3_q[p]) ? pin_s2_q[p] : pin_q[p];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            pin_s1_q <= PIN_RESET_VAL;
            pin_s2_q <= PIN_RESET_VAL;
            pin_s3_q <= PIN_RESET_VAL;
            pin_q <= PIN_RESET_VAL;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_q <= pin_d;
        end
    end

    // ----------------------------------------
    // Shared period timebase
    // ----------------------------------------
    logic [PRESC_W-1:0] presc_q;
    logic [PRESC_W-1:0] presc_d;
    logic [BASE_W-1:0] step_q;
    logic [BASE_W-1:0] step_d;
    logic [FRAC_W-1:0] frame_q;
    logic [FRAC_W-1:0] frame_d;
    logic tick;
    logic period_end;

    always_comb begin
        tick = presc_q == PRESC_LAST;
        presc_d = tick ? '0 : presc_q + 1'b1; // [R5]
        period_end = tick && (step_q == LAST_STEP);
        step_d = tick ? step_q + 1'b1 : step_q; // [R25]
        frame_d = period_end ? frame_q + 1'b1 : frame_q; // [R3]
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            presc_q <= '0;
            step_q <= '0;
            frame_q <= '0;
        end else begin
            presc_q <= presc_d;
            step_q <= step_d;
            frame_q <= frame_d;
        end
    end

    // ----------------------------------------
    // Duty computation
    // ----------------------------------------
    logic [NUM_CHANNELS-1:0][DUTY_W-1:0] duty;
    logic [NUM_CHANNELS-1:0][WIDTH_W-1:0] width_next;
    logic [COLOR_W-1:0] grp_level;
    logic [COLOR_W-1:0] own_level;
    logic [COLOR_W-1:0] color_sel;
    logic [COLOR_W-1:0] level_sel;
    logic [FRAC_W-1:0] frac;
    logic all_off;

    always_comb begin
        grp_level = intensity_curve(group_intensity_i, cfg_i.log_scale_en);
        all_off = 1'b1;
        own_level = '0;
        color_sel = '0;
        level_sel = '0;
        frac = '0;
        for (int c = 0; c < NUM_CHANNELS; c++) begin
            own_level = intensity_curve(module_intensity_i[c / CH_PER_MOD], cfg_i.log_scale_en); // [R23]
            if (module_group_select_i[c / CH_PER_MOD]) begin
                color_sel = group_color_i[c % CH_PER_MOD]; // [R10]
                level_sel = grp_level; // [R10]
            end else begin
                color_sel = channel_color_level_i[c]; // [R9] [R22]
                level_sel = own_level; // [R9]
            end
            duty[c] = final_duty(color_sel, level_sel);
            frac = cfg_i.dither_en ? duty[c][FRAC_W-1:0] : '0; // [R4]
            width_next[c] = {1'b0, duty[c][DUTY_W-1:FRAC_W]} + {9'h000, frame_q < frac}; // [R3]
            if (duty[c] != '0) begin
                all_off = 1'b0; // [R26]
            end
        end
    end

    // Widths change only at a period boundary so no pulse is cut short
    logic [NUM_CHANNELS-1:0][WIDTH_W-1:0] width_q;
    logic [NUM_CHANNELS-1:0][WIDTH_W-1:0] width_d;

    always_comb begin
        width_d = period_end ? width_next : width_q; // [R25]
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            width_q <= '0;
        end else begin
            width_q <= width_d;
        end
    end

    // ----------------------------------------
    // Mode machine
    // ----------------------------------------
    rlpwm_mode_t mode;
    logic sw_reset;
    logic drive_en;

    assign sw_reset = reset_write_i && (reset_data_i == SW_RESET_CODE); // [R18]

    rlpwm_mode_fsm #(
        .IDLE_CYCLES(IDLE_CYCLES)
    ) u_mode (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .en_i(pin_q[PIN_EN]),
        .uvlo_i(pin_q[PIN_UVLO]),
        .otemp_i(pin_q[PIN_OTEMP]),
        .sw_reset_i(sw_reset),
        .chip_en_i(cfg_i.chip_en),
        .power_save_en_i(cfg_i.power_save_en),
        .all_off_i(all_off),
        .i2c_cmd_i(i2c_cmd_i),
        .mode_o(mode)
    );

    // Power save is only reached with every duty zero, so letting it drive
    // keeps outputs coherent if a later command lights a channel.
    assign drive_en = (mode == MODE_NORMAL) || (mode == MODE_PSAVE); // [R27]

    // ----------------------------------------
    // Output stages
    // ----------------------------------------
    for (genvar g = 0; g < NUM_CHANNELS; g++) begin : g_ch
        localparam rlpwm_phase_t PH = rlpwm_phase_t'(g % CH_PER_MOD);
        rlpwm_phase_out #(
            .PHASE(PH)
        ) u_out (
            .clock_i(clock_i),
            .rstn_i(rstn_i),
            .step_i(step_q),
            .width_i(width_q[g]),
            .enable_i(drive_en),
            .sink_o(sink_output_o[g])
        );
    end

    // ----------------------------------------
    // Status outputs
    // ----------------------------------------
    logic full_scale_q;
    logic analog_q;
    logic int_reset_q;
    logic full_scale_d;
    logic analog_d;
    logic int_reset_d;

    always_comb begin
        full_scale_d = cfg_i.max_current_option; // [R12]
        analog_d = (mode == MODE_NORMAL) || (mode == MODE_TSD); // [R13]
        // Register contents survive power save and standby; init, under-voltage or the reset code clears them
        int_reset_d = (mode == MODE_INIT) || pin_q[PIN_UVLO] || sw_reset; // [R15] [R17] [R18]
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            full_scale_q <= 1'b0;
            analog_q <= 1'b0;
            int_reset_q <= 1'b1;
        end else begin
            full_scale_q <= full_scale_d;
            analog_q <= analog_d;
            int_reset_q <= int_reset_d;
        end
    end

    assign full_scale_35ma_o = full_scale_q;
    assign analog_power_o = analog_q;
    assign internal_reset_o = int_reset_q;
    assign mode_o = mode;

endmodule

`default_nettype wire

// *** design/rlpwm_pkg.sv ***
package rlpwm_pkg;

    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int NUM_CH = 24;
    localparam int NUM_MOD = 8;
    localparam int CH_PER_MOD = 3;
    localparam int COLOR_W = 8;
    localparam int PROD_W = 16;
    localparam int DUTY_W = 12;
    localparam int BASE_W = 9;
    localparam int FRAC_W = 3;
    localparam int WIDTH_W = 10;
    localparam int DUTY_LSB = PROD_W - DUTY_W;
    localparam int SYNC_DEPTH = 3;
    localparam int NUM_PINS = 3;
    localparam int PIN_EN = 0;
    localparam int PIN_UVLO = 1;
    localparam int PIN_OTEMP = 2;

    localparam logic [WIDTH_W-1:0] PERIOD_STEPS = 10'h200;
    localparam logic [WIDTH_W-1:0] MID_POINT = 10'h100;
    localparam logic [BASE_W-1:0] LAST_STEP = 9'h1FF;
    localparam logic [7:0] SW_RESET_CODE = 8'hFF;
    localparam logic [NUM_PINS-1:0] PIN_RESET_VAL = 3'h0;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int PWM_FREQ_HZ = 29_000;
    localparam int PRESCALE_RAW = CLK_HZ / (PWM_FREQ_HZ * 512);
    localparam int PWM_PRESCALE = (PRESCALE_RAW < 1) ? 1 : PRESCALE_RAW;
    localparam int PS_IDLE_TIME_MS = 30;
    localparam int PS_IDLE_CYCLES = PS_IDLE_TIME_MS * (CLK_HZ / 1000);
    localparam int IDLE_CNT_W = 20;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {PH_LEAD, PH_CENTER, PH_TRAIL} rlpwm_phase_t;

    typedef enum logic [2:0] {
        MODE_SHUTDOWN, MODE_INIT, MODE_STANDBY,
        MODE_NORMAL, MODE_PSAVE, MODE_TSD
    } rlpwm_mode_t;

    typedef struct packed {
        logic chip_en;
        logic dither_en;
        logic log_scale_en;
        logic power_save_en;
        logic max_current_option;
    } rlpwm_cfg_t;

endpackage

// *** design/rlpwm_phase_out.sv ***
`timescale 1ns/100ps
`default_nettype none

module rlpwm_phase_out
    import rlpwm_pkg::*;
#(
    parameter rlpwm_phase_t PHASE = PH_LEAD
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [BASE_W-1:0] step_i,
    input wire logic [WIDTH_W-1:0] width_i,
    input wire logic enable_i,
    output logic sink_o
);

    logic sink_q;
    logic sink_d;
    logic [WIDTH_W-1:0] pos;
    logic [WIDTH_W-1:0] lo;
    logic [WIDTH_W-1:0] hi;

    always_comb begin
        pos = {1'b0, step_i};
        lo = MID_POINT - (width_i >> 1);
        hi = lo + width_i;
        case (PHASE)
            PH_LEAD: sink_d = pos < width_i; // [R6]
            PH_CENTER: sink_d = (pos >= lo) && (pos < hi); // [R7]
            default: sink_d = pos >= (PERIOD_STEPS - width_i); // [R8]
        endcase
        if (!enable_i) begin
            sink_d = 1'b0; // [R27]
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            sink_q <= 1'b0;
        end else begin
            sink_q <= sink_d;
        end
    end

    assign sink_o = sink_q;

endmodule

`default_nettype wire

// *** design/rlpwm_mode_fsm.sv ***
`timescale 1ns/100ps
`default_nettype none

module rlpwm_mode_fsm
    import rlpwm_pkg::*;
#(
    parameter int IDLE_CYCLES = PS_IDLE_CYCLES
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic en_i,
    input wire logic uvlo_i,
    input wire logic otemp_i,
    input wire logic sw_reset_i,
    input wire logic chip_en_i,
    input wire logic power_save_en_i,
    input wire logic all_off_i,
    input wire logic i2c_cmd_i,
    output rlpwm_mode_t mode_o
);

    rlpwm_mode_t state_q;
    rlpwm_mode_t state_d;
    logic [IDLE_CNT_W-1:0] idle_q;
    logic [IDLE_CNT_W-1:0] idle_d;
    logic idle_done;

    localparam logic [IDLE_CNT_W-1:0] IDLE_LIMIT = IDLE_CNT_W'(IDLE_CYCLES);

    always_comb begin
        idle_done = idle_q >= IDLE_LIMIT;
        // Counts only while lit-free in normal mode; any nonzero duty restarts it
        if (state_q == MODE_NORMAL && all_off_i) begin
            idle_d = idle_done ? idle_q : idle_q + 1'b1; // [R26]
        end else begin
            idle_d = '0; // [R26]
        end
        state_d = state_q;
        case (state_q)
            MODE_SHUTDOWN: state_d = MODE_INIT; // [R18]
            MODE_INIT: state_d = chip_en_i ? MODE_NORMAL : MODE_STANDBY;
            MODE_STANDBY: begin
                if (chip_en_i) begin
                    state_d = MODE_NORMAL; // [R19]
                end
            end
            MODE_NORMAL: begin
                if (!chip_en_i) begin
                    state_d = MODE_STANDBY; // [R21]
                end else if (otemp_i) begin
                    state_d = MODE_TSD; // [R16]
                end else if (power_save_en_i && idle_done) begin
                    state_d = MODE_PSAVE; // [R13]
                end
            end
            MODE_PSAVE: begin
                if (!chip_en_i) begin
                    state_d = MODE_STANDBY; // [R21]
                end else if (otemp_i) begin
                    state_d = MODE_TSD; // [R16]
                end else if (i2c_cmd_i) begin
                    state_d = MODE_NORMAL; // [R14]
                end
            end
            MODE_TSD: begin
                if (!otemp_i) begin
                    state_d = chip_en_i ? MODE_NORMAL : MODE_STANDBY; // [R16]
                end
            end
            default: state_d = MODE_SHUTDOWN;
        endcase
        // Reset sources outrank every mode decision except the enable pin going low
        if (uvlo_i || sw_reset_i) begin
            state_d = MODE_INIT; // [R17] [R18]
        end
        if (!en_i) begin
            state_d = MODE_SHUTDOWN; // [R20]
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            state_q <= MODE_SHUTDOWN; // [R20]
            idle_q <= '0;
        end else begin
            state_q <= state_d;
            idle_q <= idle_d;
        end
    end

    assign mode_o = state_q;

endmodule

`default_nettype wire

// *** tb/rlpwm_bank_engine_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none

module rlpwm_bank_engine_asserts
    import rlpwm_pkg::*;
#(
    parameter int NUM_CHANNELS = NUM_CH,
    parameter int IDLE_CYCLES = PS_IDLE_CYCLES,
    parameter int PRESCALE = PWM_PRESCALE
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic en_pin_i,
    input wire logic uvlo_i,
    input wire logic over_temp_i,
    input wire rlpwm_cfg_t cfg_i,
    input wire logic reset_write_i,
    input wire logic [7:0] reset_data_i,
    input wire logic i2c_cmd_i,
    input wire logic [NUM_CHANNELS-1:0] sink_output_o,
    input wire logic internal_reset_o,
    input wire rlpwm_mode_t mode_o
);
    // Assumes PRESCALE 1; arms after a full period in normal mode,
    // since leaving forced-off may start a lead pulse mid-period
    logic prev_q;
    logic armed_q;
    logic [9:0] norm_q;
    logic [15:0] since_q;
    logic rise0;
    logic run;
    logic quiet;
    assign rise0 = sink_output_o[0] && !prev_q;
    assign run = mode_o == MODE_NORMAL || mode_o == MODE_PSAVE;
    assign quiet = en_pin_i && !uvlo_i && !over_temp_i;

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            prev_q <= 1'b0;
            armed_q <= 1'b0;
            norm_q <= 10'h000;
            since_q <= 16'h0000;
        end else begin
            prev_q <= sink_output_o[0];
            since_q <= rise0 ? 16'h0001 : since_q + 16'h0001;
            norm_q <= (mode_o != MODE_NORMAL) ? 10'h000 : norm_q + {9'h000, !norm_q[9]};
            armed_q <= (mode_o == MODE_NORMAL) && (armed_q || (rise0 && norm_q[9]));
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    property p_forced_off;
        (!run) [*3] |-> sink_output_o == '0;
    endproperty
    a_forced_off: assert property (p_forced_off) else $error("output on while stopped");
    property p_lead_period;
        rise0 && armed_q |-> since_q[8:0] == 9'h000;
    endproperty
    a_lead_period: assert property (p_lead_period) else $error("lead rise off period");
    property p_trail_end;
        $fell(sink_output_o[2]) && armed_q && mode_o == MODE_NORMAL |-> since_q[8:0] == 9'h000;
    endproperty
    a_trail_end: assert property (p_trail_end) else $error("trail fall off period");
    property p_uvlo_hold;
        (uvlo_i && en_pin_i) [*8] |-> mode_o == MODE_INIT && internal_reset_o;
    endproperty
    a_uvlo_hold: assert property (p_uvlo_hold) else $error("init not held");
    property p_en_low;
        (!en_pin_i) [*8] |-> mode_o == MODE_SHUTDOWN;
    endproperty
    a_en_low: assert property (p_en_low) else $error("no shutdown");
    property p_hot;
        over_temp_i [*8] |-> mode_o != MODE_NORMAL;
    endproperty
    a_hot: assert property (p_hot) else $error("normal while hot");
    property p_wake;
        mode_o == MODE_PSAVE && i2c_cmd_i && quiet && cfg_i.chip_en |-> ##[1:2] mode_o == MODE_NORMAL;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_sw_reset;
        reset_write_i && reset_data_i == SW_RESET_CODE && en_pin_i && mode_o != MODE_SHUTDOWN
            |-> ##[1:2] mode_o == MODE_INIT;
    endproperty
    a_sw_reset: assert property (p_sw_reset) else $error("no soft reset");
    property p_chip_en;
        mode_o == MODE_STANDBY && cfg_i.chip_en && quiet |-> ##[1:2] mode_o == MODE_NORMAL;
    endproperty
    a_chip_en: assert property (p_chip_en) else $error("no normal");

    c_wake: cover property (mode_o == MODE_PSAVE ##1 mode_o == MODE_NORMAL);
    c_hot: cover property (mode_o == MODE_TSD);
    c_armed: cover property (rise0 && armed_q);
endmodule

bind rlpwm_bank_engine rlpwm_bank_engine_asserts #(
    .NUM_CHANNELS(NUM_CHANNELS), .IDLE_CYCLES(IDLE_CYCLES), .PRESCALE(PRESCALE)
) u_chk (
    .clock_i(clock_i), .rstn_i(rstn_i), .en_pin_i(en_pin_i), .uvlo_i(uvlo_i),
    .over_temp_i(over_temp_i), .cfg_i(cfg_i), .reset_write_i(reset_write_i),
    .reset_data_i(reset_data_i), .i2c_cmd_i(i2c_cmd_i), .sink_output_o(sink_output_o),
    .internal_reset_o(internal_reset_o), .mode_o(mode_o)
);

`default_nettype wire

// *** tb/rlpwm_led_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module rlpwm_led_model
    import rlpwm_pkg::*;
(
    input wire logic clock_i,
    input wire logic clear_i,
    input wire logic [NUM_CH-1:0] sink_i,
    output logic [12:0] on_cnt_o [NUM_CH],
    output logic [9:0] rise_at_o [NUM_CH],
    output logic [9:0] fall_at_o [NUM_CH]
);
    // Edge times are taken relative to the lead channel's rise
    logic [NUM_CH-1:0] last_q;
    logic [9:0] phase_q;
    logic [9:0] phase_n;
    assign phase_n = (sink_i[0] && !last_q[0]) ? 10'h000 : phase_q + 10'h001;

    always_ff @(posedge clock_i) begin
        last_q <= sink_i;
        phase_q <= phase_n;
        for (int c = 0; c < NUM_CH; c++) begin
            if (clear_i) begin
                on_cnt_o[c] <= 13'h0000;
            end else if (sink_i[c]) begin
                on_cnt_o[c] <= on_cnt_o[c] + 13'h0001;
            end
            if (sink_i[c] && !last_q[c]) begin
                rise_at_o[c] <= phase_n;
            end
            if (!sink_i[c] && last_q[c]) begin
                fall_at_o[c] <= phase_n;
            end
        end
    end
endmodule

`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb;
    import rlpwm_pkg::*;
    localparam int IDLE = 50;
    logic clock_i = 1'b0;
    logic rstn = 1'b0;
    logic en_pin = 1'b0;
    logic uvlo = 1'b0;
    logic hot = 1'b0;
    rlpwm_cfg_t cfg = 5'h0A;
    logic [NUM_CH-1:0][7:0] color = '0;
    logic [NUM_MOD-1:0][7:0] level = '0;
    logic [NUM_MOD-1:0] gsel = 8'h00;
    logic [2:0][7:0] gcolor = '0;
    logic [7:0] glevel = 8'h00;
    logic rst_wr = 1'b0;
    logic [7:0] rst_data = 8'h00;
    logic i2c_cmd = 1'b0;
    logic clear = 1'b0;
    logic [NUM_CH-1:0] sink;
    logic full_scale;
    logic analog;
    logic int_rst;
    rlpwm_mode_t mode;
    logic [12:0] on_cnt [NUM_CH];
    logic [9:0] rise_at [NUM_CH];
    logic [9:0] fall_at [NUM_CH];
    int n_fail = 0;
    int samples_checked = 0;

    always #50 clock_i = ~clock_i;

    rlpwm_bank_engine #(.IDLE_CYCLES(IDLE)) u_dut (
        .clock_i(clock_i), .rstn_i(rstn), .en_pin_i(en_pin), .uvlo_i(uvlo), .over_temp_i(hot),
        .cfg_i(cfg), .channel_color_level_i(color), .module_intensity_i(level),
        .module_group_select_i(gsel), .group_color_i(gcolor), .group_intensity_i(glevel),
        .reset_write_i(rst_wr), .reset_data_i(rst_data), .i2c_cmd_i(i2c_cmd),
        .sink_output_o(sink), .full_scale_35ma_o(full_scale), .analog_power_o(analog),
        .internal_reset_o(int_rst), .mode_o(mode)
    );
    rlpwm_led_model u_leds (.clock_i(clock_i), .clear_i(clear), .sink_i(sink),
        .on_cnt_o(on_cnt), .rise_at_o(rise_at), .fall_at_o(fall_at));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    task automatic wait_mode(input rlpwm_mode_t m);
        int i;
        i = 0;
        while (mode !== m && i < 400) begin
            cycles(1);
            i++;
        end
        check(32'(mode), 32'(m));
        if (i == 400) print_verdict();
    endtask

    // Any 4096-cycle window covers one whole dither frame once widths settle
    task automatic measure();
        cycles(1024);
        clear = 1'b1;
        cycles(1);
        clear = 1'b0;
        cycles(4096);
    endtask

    function automatic logic [11:0] duty(input int c);
        logic [7:0] col;
        logic [7:0] lvl;
        logic [7:0] k;
        logic [15:0] p;
        col = gsel[c / 3] ? gcolor[c % 3] : color[c];
        lvl = gsel[c / 3] ? glevel : level[c / 3];
        k = cfg.log_scale_en ? 8'((16'(lvl) * 16'(lvl)) >> 8) + {7'h00, lvl[7]} : lvl;
        p = 16'(col) * 16'(k);
        return p[15:4];
    endfunction

    initial begin
        logic [11:0] d;
        logic [9:0] w;
        cycles(12);
        rstn = 1'b1;
        cycles(2);
        check(32'(mode), 32'(MODE_SHUTDOWN));
        en_pin = 1'b1;
        wait_mode(MODE_INIT);
        cycles(1);
        check(32'(int_rst), 32'h1);
        wait_mode(MODE_STANDBY);
        for (int c = 0; c < NUM_CH; c++) color[c] = 8'h10 + 8'(c * 8);
        for (int m = 0; m < NUM_MOD; m++) level[m] = 8'hFF - 8'(m * 16);
        gsel = 8'h02;
        gcolor = {8'h10, 8'h80, 8'h20};
        glevel = 8'h80;
        cycles(600);
        check(32'(sink), 32'h0);
        cfg.chip_en = 1'b1;
        wait_mode(MODE_NORMAL);
        // Analog power is registered one edge behind the mode
        cycles(1);
        check(32'(analog), 32'h1);
        for (int k = 0; k < 3; k++) begin
            cfg.dither_en = (k != 1);
            cfg.log_scale_en = (k == 2);
            measure();
            for (int c = 0; c < NUM_CH; c++) begin
                d = duty(c);
                if (!cfg.dither_en) d[2:0] = 3'h0;
                check(32'(on_cnt[c]), 32'(d));
            end
            if (k == 1) begin
                w = 10'(duty(0) >> 3);
                check(32'(rise_at[0]), 32'h0);
                check(32'(fall_at[0]), 32'(w));
                w = 10'(duty(1) >> 3);
                check(32'(rise_at[1]), 32'(10'h100 - (w >> 1)));
                check(32'(fall_at[1]), 32'(10'h100 - (w >> 1) + w));
                w = 10'(duty(2) >> 3);
                check(32'(rise_at[2]), 32'(10'h200 - w));
                check(32'(fall_at[2]), 32'h0);
            end
        end
        color = '0;
        gcolor = '0;
        cfg.power_save_en = 1'b0;
        cycles(300);
        check(32'(mode), 32'(MODE_NORMAL));
        cfg.power_save_en = 1'b1;
        wait_mode(MODE_PSAVE);
        cycles(1);
        check(32'(analog), 32'h0);
        i2c_cmd = 1'b1;
        cycles(1);
        i2c_cmd = 1'b0;
        color[0] = 8'hFF;
        check(32'(mode), 32'(MODE_NORMAL));
        hot = 1'b1;
        wait_mode(MODE_TSD);
        cycles(600);
        check(32'(sink), 32'h0);
        hot = 1'b0;
        wait_mode(MODE_NORMAL);
        for (int k = 0; k < 2; k++) begin
            cfg.max_current_option = k[0];
            cycles(3);
            check(32'(full_scale), 32'(k));
        end
        for (int k = 0; k < 2; k++) begin
            rst_data = k[0] ? 8'hFF : 8'hFE;
            rst_wr = 1'b1;
            cycles(1);
            rst_wr = 1'b0;
            check(32'(mode), k[0] ? 32'(MODE_INIT) : 32'(MODE_NORMAL));
            // Let an edge pass so the strobe is not raised again in the same step
            cycles(1);
        end
        wait_mode(MODE_NORMAL);
        uvlo = 1'b1;
        wait_mode(MODE_INIT);
        cycles(20);
        check(32'({mode, int_rst}), 32'({MODE_INIT, 1'b1}));
        uvlo = 1'b0;
        wait_mode(MODE_NORMAL);
        cfg.chip_en = 1'b0;
        wait_mode(MODE_STANDBY);
        cycles(1);
        check(32'(analog), 32'h0);
        en_pin = 1'b0;
        wait_mode(MODE_SHUTDOWN);
        print_verdict();
    end
endmodule

`default_nettype wire
